// File: bench/fabric_model.sv
// Fabric side model: debug APB slave and trigger output acknowledger
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
  // Clock, reset, wait states
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [1:0] i_wait,
  // Debug APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] i_paddr,
  input wire logic i_write,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_pready,
  output logic o_pslverr,
  // Trigger outputs
  input wire logic [7:0] i_trig,
  output logic [7:0] o_trig_ack
);
  logic [1:0] cnt_ff;
  logic [31:0] mem_ff;
  //////////////////////////////////////////////////////////////////////////////
  // Ready after i_wait access cycles; read bus is junk outside ready so stale data fails
  assign o_pready = i_psel & i_penable & (cnt_ff == i_wait);
  assign o_rdata = o_pready ? mem_ff : ~mem_ff;
  assign o_pslverr = o_pready & i_paddr[31];
  // Wait counter, storage, and acknowledge one cycle behind each trigger
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 2'h0;
      mem_ff <= 32'h0;
      o_trig_ack <= 8'h00;
    end else begin
      cnt_ff <= (i_psel & i_penable & !o_pready) ? cnt_ff + 2'h1 : 2'h0;
      if (o_pready & i_write) begin
        mem_ff <= i_wdata;
      end
      o_trig_ack <= i_trig;
    end
  end
endmodule
`default_nettype wire

// File: bench/test_debug_fabric_interface.sv
// Self-checking testbench of the debug fabric interface
`timescale 1ns/100ps
`default_nettype none
`include "dbg_fabric_consts.svh"
module test_debug_fabric_interface;
  logic clk, rst, wr, rd, dbg_en, nonin_en, tvalid, tsel, fconf, rvalid, fclk, capint;
  logic psel, pen, pwr, pready, pslverr;
  logic [1:0] wt;
  logic [7:0] addr, tin, tin_ack, tout, tout_ack;
  logic [31:0] wdata, rdata, tword, rword, tdata, paddr, pwdata, prdata, d;
  logic [43:0] ev, evo;
  logic ce;
  logic [15:0] pcin, pcout;
  logic [5:0] prin, prout;
  int errors, n_tests;
  //////////////////////////////////////////////////////////////////////////////
  // Block under test; matrix ports and probes driven by the channel scenario
  debug_fabric_interface u_dut (
    .i_clock(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_dbg_enable(dbg_en),
    .i_nonin_dbg_enable(nonin_en), .i_trace_valid(tvalid), .i_trace_word(tword),
    .o_router_valid(rvalid), .o_router_word(rword), .o_forwarded_trace_clock(fclk),
    .o_trace_data_out(tdata), .i_trace_clock_select(tsel), .i_fabric_configured(fconf),
    .o_capture_clock_internal(capint), .i_fabric_trigger_in(tin),
    .o_fabric_trigger_in_acknowledge(tin_ack), .o_fabric_trigger_out(tout),
    .i_fabric_trigger_out_acknowledge(tout_ack), .i_port_channel_in(pcin),
    .o_port_channel_out(pcout), .i_probe_channel_in(prin), .o_probe_trigger(prout),
    .o_psel(psel), .o_penable(pen), .o_paddr(paddr), .o_fabric_debug_write_select(pwr),
    .o_fabric_debug_write_bus(pwdata), .i_fabric_debug_read_bus(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .i_fabric_events(ev),
    .o_trace_macrocell_events(evo));
  // Far side of the fabric interface
  fabric_model u_fab (
    .i_clock(clk), .i_rst(rst), .i_wait(wt), .i_psel(psel), .i_penable(pen),
    .i_paddr(paddr), .i_write(pwr), .i_wdata(pwdata), .o_rdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_trig(tout), .o_trig_ack(tout_ack));
  //////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence and from any stuck wait
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic hang(input string m);
    chk(1'b0, m);
    end_sim;
  endtask
  // Register port master: one-cycle strobes, read data in the following cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Trace copy to both sinks, halved clock, held data when not valid
  task automatic t_trace;
    logic f;
    wreg(`DFI_REG_CTRL, 32'h0000_2000);
    @(posedge clk);
    tvalid <= 1'b1;
    tword <= 32'hC3A5_96E1;
    @(posedge clk);
    tvalid <= 1'b0;
    tword <= 32'h0000_0000;
    #1 chk(rvalid === 1'b1 && rword === 32'hC3A5_96E1, "router copy");
    chk(tdata === 32'hC3A5_96E1, "trace data");
    f = fclk;
    @(posedge clk);
    #1 chk(fclk === ~f && tdata === 32'hC3A5_96E1, "trace clock or hold");
    // Clock enable low must freeze the forwarded clock
    @(posedge clk);
    ce <= 1'b0;
    #1 f = fclk;
    repeat (2) @(posedge clk);
    #1 chk(fclk === f, "clock enable freeze");
    @(posedge clk);
    ce <= 1'b1;
  endtask
  // Capture clock choice over every select and configured combination
  task automatic t_capsel;
    int k;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      tsel <= k[0];
      fconf <= k[1];
      repeat (2) @(posedge clk);
      #1 chk(capint === (k[0] | ~k[1]), "capture clock");
    end
  endtask
  // Software trigger out: closed gate, enable open, gate-select open
  task automatic t_trig_out;
    int k, n;
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      dbg_en <= (k == 1);
      wreg(`DFI_REG_CTRL, {31'h0, k == 2});
      wreg(`DFI_REG_SWTRIG, 32'h1);
      for (n = 0; n < 4 && tout[0] !== 1'b1; n++) @(posedge clk);
      chk((n < 4) === (k != 0), "trigger out gate");
      for (n = 0; n < 8 && tout[0] !== 1'b0; n++) @(posedge clk);
      if (n == 8) hang("trigger out stuck");
    end
    dbg_en <= 1'b0;
  endtask
  // Fabric trigger in, seen and then masked by non-invasive enable
  task automatic t_trig_in;
    int j, n;
    wreg(`DFI_REG_CTRL, 32'h0);
    for (j = 0; j < 2; j++) begin
      wreg(`DFI_REG_STATUS, 32'h0000_FF00);
      @(posedge clk);
      nonin_en <= (j == 0);
      tin[3] <= 1'b1;
      @(posedge clk);
      #1 chk(tin_ack[3] === 1'b0, "ack not synchronised");
      for (n = 0; n < 6 && tin_ack[3] !== 1'b1; n++) @(posedge clk);
      if (n == 6) hang("no trigger ack");
      @(posedge clk);
      tin[3] <= 1'b0;
      for (n = 0; n < 6 && tin_ack[3] !== 1'b0; n++) @(posedge clk);
      if (n == 6) hang("ack stuck");
      rreg(`DFI_REG_STATUS);
      chk(d[11] === (j == 0), "trigger seen");
    end
  endtask
  // One debug APB transfer through the command register, polled to its end
  task automatic apb(input logic [31:0] a, input logic [31:0] v, input logic w,
    input logic [1:0] ws);
    int n;
    wt <= ws;
    wreg(`DFI_REG_APB_ADDR, a);
    wreg(`DFI_REG_APB_WDATA, v);
    wreg(`DFI_REG_APB_CMD, {31'h0, w});
    #1 chk(psel === 1'b1 && pen === 1'b0 && paddr === a && pwr === w, "setup");
    chk(!w || pwdata === v, "write bus");
    d = 32'h1;
    for (n = 0; n < 20 && d[0] !== 1'b0; n++) rreg(`DFI_REG_STATUS);
    if (n == 20) hang("bus stuck");
  endtask
  task automatic t_apb;
    apb(32'h0000_0040, 32'h1234_5678, 1'b1, 2'h2);
    apb(32'h0000_0044, 32'h0, 1'b0, 2'h0);
    rreg(`DFI_REG_APB_RDATA);
    chk(d === 32'h1234_5678, "read data");
    chk(psel === 1'b0 && pen === 1'b0, "bus released");
    apb(32'h8000_0000, 32'h0, 1'b0, 2'h1);
    rreg(`DFI_REG_STATUS);
    chk(d[1] === 1'b1 && d[2] === 1'b1, "slave error or clock status");
    rreg(`DFI_REG_APB_ADDR);
    chk(d === 32'h8000_0000, "address readback");
  endtask
  // Matrix channels: direct and synchronised port copies, probe paths both ways
  task automatic t_chan;
    wreg(`DFI_REG_CTRL, 32'h0);
    @(posedge clk);
    pcin <= 16'h0010;
    repeat (4) @(posedge clk);
    #1 chk(pcout === 16'h1111 && prout === 6'h11, "direct channel copy");
    chk(tout === 8'h00, "closed gate kept trigger out low");
    @(posedge clk);
    pcin <= 16'h0000;
    wreg(`DFI_REG_CTRL, 32'h0000_1E00);
    @(posedge clk);
    pcin <= 16'h0010;
    repeat (3) @(posedge clk);
    #1 chk(pcout === 16'h0000, "synchroniser too short");
    @(posedge clk);
    #1 chk(pcout === 16'h1111, "synchronised channel copy");
    @(posedge clk);
    pcin <= 16'h0000;
    prin <= 6'h20;
    repeat (6) @(posedge clk);
    #1 chk(pcout === 16'h2222 && prout === 6'h22, "probe across matrices");
    @(posedge clk);
    prin <= 6'h00;
    repeat (6) @(posedge clk);
    wreg(`DFI_REG_SWTRIG, 32'h0000_2100);
    #1 chk(prout === 6'h21, "software probe pulse");
    @(posedge clk);
    #1 chk(prout === 6'h00 && pcout === 16'h0000, "probe pulse length");
  endtask
  // Event lines give one pulse per rise, lowest and highest line
  task automatic t_events;
    @(posedge clk);
    ev <= 44'h800_0000_0001;
    @(posedge clk);
    #1 chk(evo === 44'h800_0000_0001, "event pulse");
    @(posedge clk);
    #1 chk(evo === 44'h000_0000_0000, "event level");
    @(posedge clk);
    ev <= 44'h000_0000_0000;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst, wr, rd, dbg_en, nonin_en, tvalid, tsel, fconf} = 8'h81;
    {addr, tin, wt, wdata, tword, ev} = '0;
    {pcin, prin} = '0;
    ce = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1 chk(capint === 1'b1, "capture clock reset");
    rreg(`DFI_REG_CTRL);
    chk(d === 32'h0, "control reset");
    rreg(8'hFC);
    chk(d === 32'h0, "unmapped read");
    t_trace;
    t_capsel;
    t_trig_out;
    t_trig_in;
    t_chan;
    t_apb;
    t_events;
    end_sim;
  end
endmodule
`default_nettype wire

// File: core/bit_sync.sv
// Two flip-flop level synchroniser with clock enable
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      meta_ff <= i_d;
      o_q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: core/dbg_fabric_consts.svh
// Register offsets, field positions and reset values of the debug fabric interface
`ifndef DBG_FABRIC_CONSTS_SVH
`define DBG_FABRIC_CONSTS_SVH
`define DFI_REG_CTRL 8'h00
`define DFI_REG_SWTRIG 8'h04
`define DFI_REG_APB_ADDR 8'h08
`define DFI_REG_APB_WDATA 8'h0C
`define DFI_REG_APB_CMD 8'h10
`define DFI_REG_APB_RDATA 8'h14
`define DFI_REG_STATUS 8'h18
`define DFI_CTRL_RESET 14'h0000
`define DFI_CTRL_IGATE_BIT 8
`define DFI_CTRL_SYNC_LSB 9
`define DFI_CTRL_TRACE_EN_BIT 13
`define DFI_SWTRIG_PROBE_LSB 8
`define DFI_CMD_WRITE_BIT 0
`define DFI_STATUS_SEEN_LSB 8
`define DFI_NUM_PORTS 4
`define DFI_NUM_CHAN 4
`endif

// File: core/dbg_fabric_pkg.sv
// Types shared by the debug fabric interface
package dbg_fabric_pkg;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_e;
endpackage

// File: core/debug_fabric_interface.sv
// Debug and trace boundary between the processor subsystem and the fabric
// Function
// - Replicate every trace word to both sinks
// - Forwarded trace clock is bus clock halved
// - Low sixteen data bits change every edge
// - Full 32-bit trace bus changes both edges
// - Clock select: 0 fabric, 1 internal
// - Unconfigured fabric forces internal trace clock
// - Trigger outputs gated by invasive debug enable or opened per line by control bits 7:0
// - Trigger inputs masked by non-invasive enable unless control bit DFI_CTRL_IGATE_BIT is set
// - Eight acknowledged trigger lines each way
// - Synchronise fabric triggers and acknowledges
// - Matrix channel outputs synchronised, enable per port
// - Two linked trigger matrices
// - Probes triggered by software or channels
// - Debug APB extended into the fabric
// - Write select low reads, high writes
// - 32-bit read and write data buses
// - Forty-four fabric event lines to trace macrocell
`timescale 1ns/100ps
`default_nettype none
`include "dbg_fabric_consts.svh"
module debug_fabric_interface
  import dbg_fabric_pkg::*;
#(
  parameter int NT = 8,
  parameter int NE = 44,
  parameter int NP = 6
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Authentication
  input wire logic i_dbg_enable,
  input wire logic i_nonin_dbg_enable,
  // Trace stream
  input wire logic i_trace_valid,
  input wire logic [31:0] i_trace_word,
  output logic o_router_valid,
  output logic [31:0] o_router_word,
  output logic o_forwarded_trace_clock,
  output logic [31:0] o_trace_data_out,
  // Trace capture clock choice
  input wire logic i_trace_clock_select,
  input wire logic i_fabric_configured,
  output logic o_capture_clock_internal,
  // Fabric cross triggers
  input wire logic [NT-1:0] i_fabric_trigger_in,
  output logic [NT-1:0] o_fabric_trigger_in_acknowledge,
  output logic [NT-1:0] o_fabric_trigger_out,
  input wire logic [NT-1:0] i_fabric_trigger_out_acknowledge,
  // Matrix ports and probes
  input wire logic [15:0] i_port_channel_in,
  output logic [15:0] o_port_channel_out,
  input wire logic [NP-1:0] i_probe_channel_in,
  output logic [NP-1:0] o_probe_trigger,
  // Fabric debug APB
  output logic o_psel,
  output logic o_penable,
  output logic [31:0] o_paddr,
  output logic o_fabric_debug_write_select,
  output logic [31:0] o_fabric_debug_write_bus,
  input wire logic [31:0] i_fabric_debug_read_bus,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // Event lines
  input wire logic [NE-1:0] i_fabric_events,
  output logic [NE-1:0] o_trace_macrocell_events
);
  typedef struct packed {
    logic [13:0] ctrl;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] rword;
    logic tclk;
    logic [31:0] tdata;
    logic use_int;
    logic [NT-1:0] tin_ack;
    logic [NT-1:0] tout;
    logic [NT-1:0] seen;
    logic [3:0] chan_a;
    logic [7:0] chan_b;
    logic [NP-1:0] b_in;
    logic [15:0] port_out;
    logic [NP-1:0] probe;
    apb_state_e st;
    logic psel;
    logic penable;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic pwrite;
    logic [31:0] apb_rd;
    logic err;
    logic [NE-1:0] ev_prev;
    logic [NE-1:0] ev;
  } state_s;

  state_s q;
  state_s d;
  logic [NT-1:0] tin_s;
  logic [NT-1:0] tack_s;
  logic [15:0] port_s;
  logic [NT-1:0] rise;
  logic [NT-1:0] ogate;
  logic igate;
  logic [3:0] a_src;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers from the fabric and toward the matrix ports
  bit_sync #(.W(NT)) u_tin_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d(i_fabric_trigger_in),
    .o_q(tin_s)
  );
  bit_sync #(.W(NT)) u_tack_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d(i_fabric_trigger_out_acknowledge),
    .o_q(tack_s)
  );
  bit_sync #(.W(16)) u_port_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d({`DFI_NUM_PORTS{q.chan_a}}),
    .o_q(port_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gates from the authentication levels
  always_comb begin
    ogate = q.ctrl[NT-1:0] | {NT{i_dbg_enable}};
    igate = q.ctrl[`DFI_CTRL_IGATE_BIT] | i_nonin_dbg_enable;
    rise = tin_s & ~q.tin_ack & {NT{igate}};
    // Fold eight lines, four ports and six probes onto four channels
    a_src = rise[3:0] | rise[7:4];
    a_src = a_src | i_port_channel_in[3:0] | i_port_channel_in[7:4];
    a_src = a_src | i_port_channel_in[11:8] | i_port_channel_in[15:12];
    a_src = a_src | q.b_in[3:0] | {2'b00, q.b_in[5:4]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb begin
    d = q;
    d.rvalid = i_trace_valid;
    d.rword = i_trace_word;
    if (q.ctrl[`DFI_CTRL_TRACE_EN_BIT]) begin
      d.tclk = ~q.tclk;
      // Each bus clock is one edge of the forwarded clock
      if (i_trace_valid) begin
        d.tdata = i_trace_word;
      end
    end
    // Unconfigured fabric gives no clock, so fall back to internal
    d.use_int = i_trace_clock_select | ~i_fabric_configured;

    // Acknowledge follows the synchronised trigger level
    d.tin_ack = tin_s;
    // Link of the two matrices uses registered copies, so no ring forms
    d.chan_a = a_src;
    d.b_in = i_probe_channel_in;
    d.chan_b = {2'b00, q.b_in | {q.chan_a[1:0], q.chan_a}};
    d.probe = q.chan_b[NP-1:0];
    for (int p = 0; p < `DFI_NUM_PORTS; p++) begin
      if (q.ctrl[`DFI_CTRL_SYNC_LSB + p]) begin
        d.port_out[p*4 +: 4] = port_s[p*4 +: 4];
      end else begin
        d.port_out[p*4 +: 4] = q.chan_a;
      end
    end

    // Outgoing handshake: raise, hold until acknowledged, then drop
    for (int i = 0; i < NT; i++) begin
      if (!ogate[i] || tack_s[i]) begin
        d.tout[i] = 1'b0;
      end else if (q.chan_a[i % 4]) begin
        d.tout[i] = 1'b1;
      end
    end

    // Event lines become one-cycle pulses on a rising edge
    d.ev_prev = i_fabric_events;
    d.ev = i_fabric_events & ~q.ev_prev;

    // Register writes
    d.seen = q.seen | rise;
    if (i_wr) begin
      unique case (i_addr)
        `DFI_REG_CTRL: d.ctrl = i_wdata[13:0];
        `DFI_REG_SWTRIG: begin
          for (int i = 0; i < NT; i++) begin
            if (i_wdata[i] && ogate[i] && !tack_s[i]) begin
              d.tout[i] = 1'b1;
            end
          end
          d.probe = q.chan_b[NP-1:0] | i_wdata[`DFI_SWTRIG_PROBE_LSB +: NP];
        end
        `DFI_REG_APB_ADDR: d.paddr = (q.st == APB_IDLE) ? i_wdata : q.paddr;
        `DFI_REG_APB_WDATA: d.pwdata = (q.st == APB_IDLE) ? i_wdata : q.pwdata;
        `DFI_REG_APB_CMD: begin
          // A command while busy is dropped; the bus is never stalled
          if (q.st == APB_IDLE) begin
            d.pwrite = i_wdata[`DFI_CMD_WRITE_BIT];
            d.st = APB_SETUP;
            d.psel = 1'b1;
            d.err = 1'b0;
          end
        end
        // New arrivals win over the write-one clear
        `DFI_REG_STATUS: d.seen = (q.seen & ~i_wdata[15:8]) | rise;
        default: ;
      endcase
    end

    // Fabric debug APB master
    unique case (q.st)
      APB_IDLE: ;
      APB_SETUP: begin
        d.st = APB_ACCESS;
        d.penable = 1'b1;
      end
      APB_ACCESS: begin
        if (i_pready) begin
          d.st = APB_IDLE;
          d.psel = 1'b0;
          d.penable = 1'b0;
          d.err = i_pslverr;
          if (!q.pwrite) begin
            d.apb_rd = i_fabric_debug_read_bus;
          end
        end
      end
      default: begin
        d.st = APB_IDLE;
        d.psel = 1'b0;
        d.penable = 1'b0;
      end
    endcase

    // Read data stand for one cycle only
    d.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        `DFI_REG_CTRL: d.rdata = {18'h0, q.ctrl};
        `DFI_REG_APB_ADDR: d.rdata = q.paddr;
        `DFI_REG_APB_WDATA: d.rdata = q.pwdata;
        `DFI_REG_APB_RDATA: d.rdata = q.apb_rd;
        `DFI_REG_STATUS: d.rdata = {16'h0000, q.seen, 5'h00, q.use_int, q.err,
                                    q.st != APB_IDLE};
        default: d.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.ctrl <= `DFI_CTRL_RESET;
      q.use_int <= 1'b1;
      q.st <= APB_IDLE;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = q.rdata;
  assign o_router_valid = q.rvalid;
  assign o_router_word = q.rword;
  assign o_forwarded_trace_clock = q.tclk;
  assign o_trace_data_out = q.tdata;
  assign o_capture_clock_internal = q.use_int;
  assign o_fabric_trigger_in_acknowledge = q.tin_ack;
  assign o_fabric_trigger_out = q.tout;
  assign o_port_channel_out = q.port_out;
  assign o_probe_trigger = q.probe;
  assign o_psel = q.psel;
  assign o_penable = q.penable;
  assign o_paddr = q.paddr;
  assign o_fabric_debug_write_select = q.pwrite;
  assign o_fabric_debug_write_bus = q.pwdata;
  assign o_trace_macrocell_events = q.ev;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic trace_en;
  logic [NT-1:0] osel;
  logic [NT-1:0] seen_q;
  assign trace_en = q.ctrl[`DFI_CTRL_TRACE_EN_BIT];
  assign osel = q.ctrl[NT-1:0];
  assign seen_q = q.seen;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  AST_REPLICA: assert property (i_ce |=> o_router_word == $past(i_trace_word) &&
    o_router_valid == $past(i_trace_valid)) else $error("replica differs");
  AST_CLK_DIV: assert property (i_ce && trace_en |=>
    o_forwarded_trace_clock != $past(o_forwarded_trace_clock)) else $error("no toggle");
  AST_LOW_DATA: assert property (i_ce && trace_en && i_trace_valid |=>
    o_trace_data_out[15:0] == $past(i_trace_word[15:0])) else $error("low data stale");
  AST_WIDE_HOLD: assert property (i_ce && !i_trace_valid |=>
    $stable(o_trace_data_out)) else $error("trace data moved");
  AST_CLK_SEL: assert property (i_ce && i_fabric_configured |=>
    o_capture_clock_internal == $past(i_trace_clock_select)) else $error("bad clock select");
  AST_FALLBACK: assert property (i_ce && !i_fabric_configured |=>
    o_capture_clock_internal) else $error("no fallback");
  AST_OUT_GATE: assert property (i_ce && !i_dbg_enable |=>
    (o_fabric_trigger_out & ~$past(osel)) == '0) else $error("trigger out not gated");
  AST_IN_MASK: assert property (i_ce && !i_nonin_dbg_enable &&
    !q.ctrl[`DFI_CTRL_IGATE_BIT] |=> (seen_q & ~$past(seen_q)) == '0)
    else $error("trigger in not masked");
  AST_IN_ACK: assert property (i_ce [*3] |=>
    o_fabric_trigger_in_acknowledge == $past(i_fabric_trigger_in, 3)) else $error("ack late");
  AST_APB_ENABLE: assert property (o_psel && !o_penable && i_ce |=>
    o_psel && o_penable) else $error("no access phase");
  AST_APB_HOLD: assert property (o_penable && !(i_ce && i_pready) |=>
    o_penable && $stable(o_paddr) && $stable(o_fabric_debug_write_select))
    else $error("access not held");
  AST_EVENT: assert property (i_ce ##1 i_ce |=>
    o_trace_macrocell_events == ($past(i_fabric_events) & ~$past(i_fabric_events, 2)))
    else $error("event pulse wrong");

  COV_APB_READ: cover property (o_penable && i_pready && !o_fabric_debug_write_select);
  COV_TRIG_OUT: cover property ($rose(o_fabric_trigger_out[0]));
  COV_FALLBACK: cover property (i_trace_clock_select == 1'b0 && !i_fabric_configured);
endmodule
`default_nettype wire
